// ---- rtl/sgc_pkg.sv ----
`default_nettype none
package sgc_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] OFS_HOST_STORM  = 8'h06;
    localparam logic [7:0] OFS_STORM_LOW   = 8'h07;
    localparam logic [7:0] OFS_FTEST_A     = 8'h08;
    localparam logic [7:0] OFS_FTEST_B     = 8'h09;
    localparam logic [7:0] OFS_FTEST_C     = 8'h0A;
    localparam logic [7:0] OFS_CLK_LED     = 8'h0B;
    // ****************************************
    // field positions
    // ****************************************
    localparam int BIT_FLOW_CTRL  = 5;
    localparam int BIT_SPEED_10   = 4;
    localparam int BIT_NULL_VID   = 3;
    localparam int BIT_LOW_REFCLK = 7;
    localparam int BIT_UP_REFCLK  = 6;
    localparam int BIT_PWR_SAVE   = 3;
    localparam int BIT_LED_MODE   = 1;
    localparam int BIT_RD_EDGE    = 0;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [2:0] RST_STORM_HIGH  = 3'h0;
    localparam logic [7:0] RST_STORM_LOW   = 8'h4A;
    localparam logic [7:0] RST_FTEST_A     = 8'h00;
    localparam logic [7:0] RST_FTEST_B     = 8'h4C;
    localparam logic [7:0] RST_FTEST_C     = 8'h00;
    // ****************************************
    // storm period timing
    // ****************************************
    localparam int CLK_MHZ         = 100;
    localparam int PERIOD_100_MS   = 50;
    localparam int PERIOD_10_MS    = 500;
    localparam int CYC_PER_MS      = CLK_MHZ * 1000;
    localparam int PERIOD_100_CYC  = PERIOD_100_MS * CYC_PER_MS;
    localparam int PERIOD_10_CYC   = PERIOD_10_MS * CYC_PER_MS;
endpackage : sgc_pkg
`default_nettype wire

// ---- rtl/sgc_regs.sv ----
// Overview of operation
// R1 - bit5: upper host port flow control, strap default
// R2 - bit4: upper host speed 10M/100M, strap default
// R3 - bit3: replace null VLAN ID, resets 0
// R4 - 11-bit storm threshold split over two registers
// R5 - storm period 50ms at 100M, 500ms at 10M
// R6 - threshold resets to 0x04A, about one percent
// R7 - refclk sampling edge per host port
// R8 - bit0: management read sampling edge select
// R9 - bit1: LED mode, strap default
`default_nettype none
module sgc_regs
    import sgc_pkg::*;
#(
    parameter int PERIOD_100 = sgc_pkg::PERIOD_100_CYC,
    parameter int PERIOD_10  = sgc_pkg::PERIOD_10_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        flow_ctrl_strap_pin,
    input  wire logic        speed_strap_pin,
    input  wire logic        led_mode_strap_pin,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rvalid,
    output logic             upper_flow_ctrl_en,
    output logic             upper_speed_10,
    output logic             null_vid_replace,
    output logic      [10:0] storm_threshold,
    output logic             storm_period_tick,
    output logic             lower_refclk_negedge,
    output logic             upper_refclk_negedge,
    output logic             phy_power_save,
    output logic             led_mode,
    output logic             mgmt_rd_rising_edge
);
    import sgc_pkg::*;

    // ****************************************
    // strap capture
    // ****************************************
    // straps are latched on the first edge after release, never under reset
    logic strap_done;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            strap_done <= 1'b0;
        end else begin
            strap_done <= 1'b1;
        end
    end

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction : hit

    // ****************************************
    // write decode
    // ****************************************
    // the strap cycle belongs to the straps, so a write landing there is dropped
    logic wr_host_storm;
    logic wr_storm_low;
    logic wr_clk_led;
    assign wr_host_storm = reg_wr && strap_done && hit(reg_addr, OFS_HOST_STORM);
    assign wr_storm_low  = reg_wr && strap_done && hit(reg_addr, OFS_STORM_LOW);
    assign wr_clk_led    = reg_wr && strap_done && hit(reg_addr, OFS_CLK_LED);

    // ****************************************
    // host port control
    // ****************************************
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            upper_flow_ctrl_en <= 1'b0;
        end else if (!strap_done) begin
            upper_flow_ctrl_en <= flow_ctrl_strap_pin;               // R1
        end else if (wr_host_storm) begin
            upper_flow_ctrl_en <= reg_wdata[BIT_FLOW_CTRL];          // R1
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            upper_speed_10 <= 1'b0;
        end else if (!strap_done) begin
            upper_speed_10 <= speed_strap_pin;                       // R2
        end else if (wr_host_storm) begin
            upper_speed_10 <= reg_wdata[BIT_SPEED_10];               // R2
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            null_vid_replace <= 1'b0;                                // R3
        end else if (wr_host_storm) begin
            null_vid_replace <= reg_wdata[BIT_NULL_VID];             // R3
        end
    end

    // ****************************************
    // broadcast storm threshold
    // ****************************************
    // halves are written independently; software sees a mixed value between the two writes
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            storm_threshold <= {RST_STORM_HIGH, RST_STORM_LOW};      // R6
        end else begin
            if (wr_host_storm) begin
                storm_threshold[10:8] <= reg_wdata[2:0];             // R4
            end
            if (wr_storm_low) begin
                storm_threshold[7:0] <= reg_wdata;                   // R4
            end
        end
    end

    // ****************************************
    // clock edge and led control
    // ****************************************
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lower_refclk_negedge <= 1'b0;
            upper_refclk_negedge <= 1'b0;
        end else if (wr_clk_led) begin
            lower_refclk_negedge <= reg_wdata[BIT_LOW_REFCLK];       // R7
            upper_refclk_negedge <= reg_wdata[BIT_UP_REFCLK];        // R7
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            phy_power_save <= 1'b0;
        end else if (wr_clk_led) begin
            phy_power_save <= reg_wdata[BIT_PWR_SAVE];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            led_mode <= 1'b0;
        end else if (!strap_done) begin
            led_mode <= led_mode_strap_pin;                          // R9
        end else if (wr_clk_led) begin
            led_mode <= reg_wdata[BIT_LED_MODE];                     // R9
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mgmt_rd_rising_edge <= 1'b0;
        end else if (wr_clk_led) begin
            mgmt_rd_rising_edge <= reg_wdata[BIT_RD_EDGE];           // R8
        end
    end

    // ****************************************
    // storm measurement period
    // ****************************************
    // one counter serves the upper host port; the length follows its speed
    logic [31:0] period_cnt;
    logic [31:0] period_len;
    assign period_len = upper_speed_10 ? 32'(PERIOD_10) : 32'(PERIOD_100);   // R5
    logic period_end;
    assign period_end = period_cnt >= period_len - 32'h1;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            period_cnt <= 32'h0;
        end else if (period_end) begin
            period_cnt <= 32'h0;                                     // R5
        end else begin
            period_cnt <= period_cnt + 32'h1;
        end
    end

    // tick is registered so the pin stays glitch free
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            storm_period_tick <= 1'b0;
        end else begin
            storm_period_tick <= period_end;                         // R5
        end
    end

    // ****************************************
    // read path
    // ****************************************
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        unique case (reg_addr)
            OFS_HOST_STORM: begin
                next_rdata[BIT_FLOW_CTRL] = upper_flow_ctrl_en;
                next_rdata[BIT_SPEED_10]  = upper_speed_10;
                next_rdata[BIT_NULL_VID]  = null_vid_replace;
                next_rdata[2:0]           = storm_threshold[10:8];
            end
            OFS_STORM_LOW: next_rdata = storm_threshold[7:0];
            OFS_FTEST_A:   next_rdata = RST_FTEST_A;
            OFS_FTEST_B:   next_rdata = RST_FTEST_B;
            OFS_FTEST_C:   next_rdata = RST_FTEST_C;
            OFS_CLK_LED: begin
                // reserved bits stay zero from the default above
                next_rdata[BIT_LOW_REFCLK] = lower_refclk_negedge;
                next_rdata[BIT_UP_REFCLK]  = upper_refclk_negedge;
                next_rdata[BIT_PWR_SAVE]   = phy_power_save;
                next_rdata[BIT_LED_MODE]   = led_mode;
                next_rdata[BIT_RD_EDGE]    = mgmt_rd_rising_edge;
            end
            default:       next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
        end
    end

    // data holds between reads so a slow host can pick it up late
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end
endmodule : sgc_regs
`default_nettype wire

// ---- dv/sgc_props.sv ----
`default_nettype none
module sgc_props
    import sgc_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic        flow_ctrl_strap_pin,
    input wire logic        speed_strap_pin,
    input wire logic        led_mode_strap_pin,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        upper_flow_ctrl_en,
    input wire logic        upper_speed_10,
    input wire logic        null_vid_replace,
    input wire logic [10:0] storm_threshold,
    input wire logic        storm_period_tick,
    input wire logic        lower_refclk_negedge,
    input wire logic        upper_refclk_negedge,
    input wire logic        led_mode,
    input wire logic        mgmt_rd_rising_edge
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********************
    // write, reset, strap and tick effects
    // ********************
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    wire w6 = reg_wr && reg_addr == OFS_HOST_STORM;
    wire w7 = reg_wr && reg_addr == OFS_STORM_LOW;
    wire wb = reg_wr && reg_addr == OFS_CLK_LED;
    AST_FLOW: assert property (w6 |=> upper_flow_ctrl_en == $past(reg_wdata[5])) else $error("flow");
    AST_SPEED: assert property (w6 |=> upper_speed_10 == $past(reg_wdata[4])) else $error("speed");
    AST_VID: assert property (w6 |=> null_vid_replace == $past(reg_wdata[3])) else $error("vid");
    AST_THR_HI: assert property (w6 |=> storm_threshold[10:8] == $past(reg_wdata[2:0])) else $error("hi");
    AST_THR_LO: assert property (w7 |-> ##1 storm_threshold[7:0] == $past(reg_wdata)) else $error("lo");
    AST_REFCLK: assert property (wb |=> lower_refclk_negedge == $past(reg_wdata[7])) else $error("ref");
    AST_LED: assert property (wb |=> led_mode == $past(reg_wdata[1])) else $error("led");
    AST_RD_EDGE: assert property (wb |=> mgmt_rd_rising_edge == $past(reg_wdata[0])) else $error("edge");
    AST_UP_REFCLK: assert property (wb |=> upper_refclk_negedge == $past(reg_wdata[6])) else $error("up ref");
    AST_THR_KEEP: assert property (w7 |=> storm_threshold[10:8] == $past(storm_threshold[10:8])) else $error("keep");
    AST_RST_THR: assert property ($rose(nrst) |-> storm_threshold == 11'h04A) else $error("rst thr");
    AST_RST_VID: assert property ($rose(nrst) |-> !null_vid_replace) else $error("rst vid");
    AST_RST_REF: assert property ($rose(nrst) |-> !lower_refclk_negedge && !upper_refclk_negedge) else $error("rst ref");
    AST_RST_EDGE: assert property ($rose(nrst) |-> !mgmt_rd_rising_edge) else $error("rst edge");
    wire [2:0] strap_in  = {flow_ctrl_strap_pin, speed_strap_pin, led_mode_strap_pin};
    wire [2:0] strap_out = {upper_flow_ctrl_en, upper_speed_10, led_mode};
    AST_STRAP: assert property ($rose(nrst) |=> strap_out == $past(strap_in)) else $error("strap");
    AST_TICK: assert property (storm_period_tick |=> !storm_period_tick) else $error("tick");
endmodule : sgc_props
bind sgc_regs sgc_props sgc_props_inst (.core_clk, .nrst, .flow_ctrl_strap_pin, .speed_strap_pin,
    .led_mode_strap_pin, .reg_wr, .reg_addr, .reg_wdata, .upper_flow_ctrl_en, .upper_speed_10, .null_vid_replace,
    .storm_threshold, .storm_period_tick, .lower_refclk_negedge, .upper_refclk_negedge, .led_mode,
    .mgmt_rd_rising_edge);
`default_nettype wire

// ---- dv/sgc_regs_test.sv ----
`default_nettype none
module sgc_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    import sgc_pkg::*;
    // ********************
    // bench
    // ********************
    logic core_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid, storm_period_tick;
    logic flow_ctrl_strap_pin = 1'b1, speed_strap_pin = 1'b0, led_mode_strap_pin = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic upper_flow_ctrl_en, upper_speed_10, null_vid_replace, lower_refclk_negedge, upper_refclk_negedge;
    logic phy_power_save, led_mode, mgmt_rd_rising_edge;
    logic [10:0] storm_threshold;
    int num_errors = 0, checks = 0;
    // short periods keep the run small
    sgc_regs #(.PERIOD_100(20), .PERIOD_10(200)) sgc_regs_inst (.core_clk, .nrst, .flow_ctrl_strap_pin,
        .speed_strap_pin, .led_mode_strap_pin, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
        .upper_flow_ctrl_en, .upper_speed_10, .null_vid_replace, .storm_threshold, .storm_period_tick,
        .lower_refclk_negedge, .upper_refclk_negedge, .phy_power_save, .led_mode, .mgmt_rd_rising_edge);
    always #5 core_clk = ~core_clk;
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk) #1;
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(posedge core_clk) #1;
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk) #1;
        {reg_rd, reg_addr} = {1'b1, a};
        @(posedge core_clk) #1;
        reg_rd = 1'b0;
        cmp({reg_rvalid, reg_rdata}, {1'b1, e});
    endtask : rd
    task automatic t_straps();
        @(posedge core_clk) #1;
        cmp({upper_flow_ctrl_en, upper_speed_10, null_vid_replace, led_mode}, 4'h9);
        rd(OFS_STORM_LOW, 8'h4A);
        rd(OFS_CLK_LED, 8'h02);
        rd(OFS_HOST_STORM, 8'h20);
    endtask : t_straps
    task automatic t_period(input int len);
        int n;
        repeat (3) begin
            n = 0;
            do begin
                @(posedge core_clk) #1;
                n++;
            end while (storm_period_tick !== 1'b1 && n < 1000);
        end
        cmp(16'(n), 16'(len));
    endtask : t_period
    task automatic t_rw();
        wr(OFS_HOST_STORM, 8'h3D);
        cmp({upper_flow_ctrl_en, upper_speed_10, null_vid_replace, storm_threshold}, {3'h7, 11'h54A});
        wr(OFS_STORM_LOW, 8'h10);
        cmp(storm_threshold, 11'h510);
        wr(OFS_CLK_LED, 8'hFF);
        cmp({lower_refclk_negedge, upper_refclk_negedge, phy_power_save, led_mode, mgmt_rd_rising_edge},
            5'h1F);
        rd(OFS_CLK_LED, 8'hCB);
        rd(OFS_HOST_STORM, 8'h3D);
    endtask : t_rw
    task automatic t_reset();
        @(posedge core_clk) #1;
        {nrst, flow_ctrl_strap_pin, speed_strap_pin, led_mode_strap_pin} = 4'h2;
        @(posedge core_clk) #1;
        cmp({upper_flow_ctrl_en, upper_speed_10, null_vid_replace, storm_threshold}, {3'h0, 11'h04A});
        cmp({lower_refclk_negedge, upper_refclk_negedge, phy_power_save, led_mode, mgmt_rd_rising_edge},
            5'h00);
        @(posedge core_clk) #1;
        nrst = 1'b1;
        @(posedge core_clk) #1;
        cmp({upper_flow_ctrl_en, upper_speed_10, null_vid_replace, led_mode}, 4'h4);
        rd(OFS_HOST_STORM, 8'h10);
        rd(OFS_CLK_LED, 8'h00);
    endtask : t_reset
    task automatic t_ro();
        wr(OFS_FTEST_B, 8'hFF);
        rd(OFS_FTEST_B, 8'h4C);
        rd(OFS_FTEST_A, 8'h00);
        rd(OFS_FTEST_C, 8'h00);
        rd(8'h20, 8'h00);
    endtask : t_ro
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (4) @(posedge core_clk);
        #1 nrst = 1'b1;
        cmp(storm_threshold, 11'h04A);
        t_straps();
        t_period(20);
        t_rw();
        t_period(200);
        t_reset();
        t_ro();
        tally_and_finish();
    end
    initial begin
        #20000;
        num_errors++;
        tally_and_finish();
    end
endmodule : sgc_regs_test
`default_nettype wire
